// file: core/power_fault_status_summary.sv
/*
  Read-only fault status bank: summary byte, summary word and paged
  output voltage/current detail flags for a dual-output regulator.
  Assumes live fault levels from the regulator core on the same clock,
  and a command decoder that strobes a read with command code and page.
*/
`default_nettype none
module power_fault_status_summary #(
  parameter int PAGES = fault_status_pkg::NUM_PAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Per-output fault levels from the regulator core
  input wire logic [PAGES-1:0] out_off,
  input wire logic [PAGES-1:0] vout_ov_fault,
  input wire logic [PAGES-1:0] vout_uv_fault,
  input wire logic [PAGES-1:0] vout_max_warn,
  input wire logic [PAGES-1:0] iout_oc_fault,
  input wire logic [PAGES-1:0] iout_oc_uv_fault,
  input wire logic [PAGES-1:0] iout_share_fault,
  input wire logic [PAGES-1:0] pgood_n,
  // Global fault levels
  input wire logic vin_uv_fault,
  input wire logic input_fault_any,
  input wire logic temp_fault_any,
  input wire logic cml_fault_any,
  input wire logic mfr_event,
  input wire logic other_event,
  // Status read port
  input wire logic rd_strobe,
  input wire logic [7:0] rd_cmd,
  input wire logic [$clog2(PAGES)-1:0] rd_page,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_unmapped
);

  // Per-page detail bytes; unused positions are tied to zero
  logic [7:0] vout_flags [PAGES];
  logic [7:0] iout_flags [PAGES];
  logic [7:0] summary_byte;
  logic [15:0] summary_word;
  logic [PAGES-1:0] vout_any;
  logic [PAGES-1:0] iout_any;
  logic [15:0] rd_data_nxt;
  logic rd_hit;

  // True for the four command codes that this bank answers
  function automatic logic is_mapped(input logic [7:0] cmd);
    return cmd inside {fault_status_pkg::CMD_SUMMARY_BYTE,
      fault_status_pkg::CMD_SUMMARY_WORD, fault_status_pkg::CMD_VOUT_FLAGS,
      fault_status_pkg::CMD_IOUT_FLAGS};
  endfunction

  // Detail flag builders, one per output
  genvar g;
  generate
    for (g = 0; g < PAGES; g++) begin : g_page
      always_comb begin
        vout_flags[g] = 8'h00;
        vout_flags[g][fault_status_pkg::VF_OV] = vout_ov_fault[g];
        vout_flags[g][fault_status_pkg::VF_UV] = vout_uv_fault[g];
        vout_flags[g][fault_status_pkg::VF_MAX_WARN] =
          vout_max_warn[g];
        iout_flags[g] = 8'h00;
        iout_flags[g][fault_status_pkg::IF_OC] = iout_oc_fault[g];
        iout_flags[g][fault_status_pkg::IF_OC_UV] =
          iout_oc_uv_fault[g];
        iout_flags[g][fault_status_pkg::IF_SHARE] =
          iout_share_fault[g];
      end
      assign vout_any[g] = |vout_flags[g];
      assign iout_any[g] = |iout_flags[g];
    end
  endgenerate

  // Global summary byte, ORed over both outputs
  always_comb begin
    summary_byte = 8'h00;
    summary_byte[fault_status_pkg::SB_OFF] = |out_off;
    summary_byte[fault_status_pkg::SB_VOUT_OV] = |vout_ov_fault;
    summary_byte[fault_status_pkg::SB_IOUT_OC] = |iout_oc_fault;
    summary_byte[fault_status_pkg::SB_VIN_UV] = vin_uv_fault;
    summary_byte[fault_status_pkg::SB_TEMP] = temp_fault_any;
    summary_byte[fault_status_pkg::SB_CML] = cml_fault_any;
    summary_byte[fault_status_pkg::SB_NONE_ABOVE] = other_event;
  end

  // Global summary word; low byte is the summary byte itself
  always_comb begin
    summary_word = {8'h00, summary_byte};
    summary_word[fault_status_pkg::SW_VOUT] = |vout_any;
    summary_word[fault_status_pkg::SW_IOUT] = |iout_any;
    summary_word[fault_status_pkg::SW_INPUT] =
      input_fault_any | vin_uv_fault;
    summary_word[fault_status_pkg::SW_MFR] = mfr_event;
    summary_word[fault_status_pkg::SW_PGOOD_N] = |pgood_n;
  end

  // Read mux; no write path exists at all
  always_comb begin
    rd_data_nxt = 16'h0000;
    rd_hit = is_mapped(rd_cmd);
    case (rd_cmd)
      fault_status_pkg::CMD_SUMMARY_BYTE:
        rd_data_nxt = {8'h00, summary_byte};
      fault_status_pkg::CMD_SUMMARY_WORD:
        rd_data_nxt = summary_word;
      fault_status_pkg::CMD_VOUT_FLAGS:
        rd_data_nxt = {8'h00, vout_flags[rd_page]};
      fault_status_pkg::CMD_IOUT_FLAGS:
        rd_data_nxt = {8'h00, iout_flags[rd_page]};
      default:
        rd_data_nxt = 16'h0000;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= fault_status_pkg::RDATA_RESET;
      rd_valid <= 1'b0;
      rd_unmapped <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
      rd_unmapped <= rd_strobe & ~rd_hit;
      if (rd_strobe) begin
        rd_data <= rd_data_nxt;
      end
    end
  end

  // Summary byte read: each bit against the live fault levels
  a_byte_off: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[6] == $past(|out_off) && rd_data[15:7] == 9'h000)
    else $error("summary byte off bit wrong");

  a_byte_ov: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[5] == $past(|vout_ov_fault))
    else $error("summary byte ov bit wrong");

  a_byte_oc: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[4] == $past(|iout_oc_fault))
    else $error("summary byte oc bit wrong");

  a_byte_vin: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[3] == $past(vin_uv_fault))
    else $error("summary byte input undervoltage bit wrong");

  a_byte_temp: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[2] == $past(temp_fault_any))
    else $error("summary byte temperature bit wrong");

  a_byte_cml: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[1] == $past(cml_fault_any))
    else $error("summary byte cml bit wrong");

  a_byte_other: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE |=>
    rd_data[0] == $past(other_event))
    else $error("summary byte other bit wrong");

  // Summary word read: high byte classes and the copied low byte
  a_word_low: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_WORD |=>
    rd_data[7:0] == $past({1'b0, |out_off, |vout_ov_fault, |iout_oc_fault,
    vin_uv_fault, temp_fault_any, cml_fault_any, other_event}))
    else $error("word low byte differs from byte");

  a_word_vout: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_WORD |=>
    rd_data[15] == $past(|(vout_ov_fault | vout_uv_fault | vout_max_warn))
    && rd_data[10:7] == 4'h0)
    else $error("word vout bit wrong");

  a_word_iout: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_WORD |=>
    rd_data[14] == $past(|(iout_oc_fault | iout_oc_uv_fault |
    iout_share_fault)))
    else $error("word iout bit wrong");

  a_word_input: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_WORD |=>
    rd_data[13] == $past(input_fault_any | vin_uv_fault))
    else $error("word input bit wrong");

  a_word_mfr: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_WORD |=>
    rd_data[12] == $past(mfr_event))
    else $error("word manufacturer bit wrong");

  a_word_pgood: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_WORD |=>
    rd_data[11] == $past(|pgood_n))
    else $error("word power good bit wrong");

  // Voltage detail read for the selected page
  a_vout_ov: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_VOUT_FLAGS |=>
    rd_data[7] == $past(vout_ov_fault[rd_page]))
    else $error("voltage flags ov bit wrong");

  a_vout_uv: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_VOUT_FLAGS |=>
    rd_data[4] == $past(vout_uv_fault[rd_page]))
    else $error("voltage flags uv bit wrong");

  a_vout_warn: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_VOUT_FLAGS |=>
    rd_data[3] == $past(vout_max_warn[rd_page]))
    else $error("voltage flags warning bit wrong");

  a_vout_unused: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_VOUT_FLAGS |=>
    rd_data[15:8] == 8'h00 && rd_data[6:5] == 2'b00 &&
    rd_data[2:0] == 3'b000)
    else $error("voltage flags unused bits set");

  // Current detail read for the selected page
  a_iout_page: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_IOUT_FLAGS |=>
    rd_data[7] == $past(iout_oc_fault[rd_page]) &&
    rd_data[3] == $past(iout_share_fault[rd_page]))
    else $error("current flags wrong for page");

  a_iout_ocuv: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_IOUT_FLAGS |=>
    rd_data[6] == $past(iout_oc_uv_fault[rd_page]))
    else $error("current flags oc-uv bit wrong");

  a_iout_share: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_IOUT_FLAGS |=>
    rd_data[3] == $past(iout_share_fault[rd_page]))
    else $error("current flags share bit wrong");

  a_iout_unused: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_IOUT_FLAGS |=>
    rd_data[15:8] == 8'h00 && rd_data[5:4] == 2'b00 &&
    rd_data[2:0] == 3'b000)
    else $error("current flags unused bits set");

  // Read port timing and unknown commands
  a_read_lat: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe |=> rd_valid ##1 (rd_valid == $past(rd_strobe)))
    else $error("read answer latency wrong");

  a_unmap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && !is_mapped(rd_cmd) |=> rd_unmapped && rd_data == 16'h0000)
    else $error("unknown command answered wrongly");

  a_mapped_hit: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && is_mapped(rd_cmd) |=> rd_valid && !rd_unmapped)
    else $error("known command flagged as unmapped");

  a_unmap_valid: assert property (@(posedge clk) disable iff (!rst_n)
    rd_unmapped |-> rd_valid)
    else $error("unmapped flag without valid answer");

  a_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_strobe |=> $stable(rd_data))
    else $error("read data changed without a read");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_strobe |=> !rd_valid && !rd_unmapped)
    else $error("answer strobe without a read");

  // Main scenarios to be reached
  c_byte_read: cover property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_cmd == fault_status_pkg::CMD_SUMMARY_BYTE);
  c_word_fault: cover property (@(posedge clk) disable iff (!rst_n)
    rd_valid && rd_data[15] && rd_data[14]);
  c_page_one: cover property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && rd_page != 0 &&
    rd_cmd == fault_status_pkg::CMD_VOUT_FLAGS);
  c_unmapped: cover property (@(posedge clk) disable iff (!rst_n)
    rd_unmapped);

endmodule // power_fault_status_summary
`default_nettype wire

// file: core/fault_status_pkg.sv
/*
  Constants for the fault status summary bank: command codes, bit
  positions of summary and detail registers, and the page count.
  Assumes a command decoder outside that presents a read command code.
*/
`default_nettype none
package fault_status_pkg;
  // Command codes of the four status reads
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
  localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
  // Summary bit positions
  localparam int SB_NONE_ABOVE = 0;
  localparam int SB_CML = 1;
  localparam int SB_TEMP = 2;
  localparam int SB_VIN_UV = 3;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_OFF = 6;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_MFR = 12;
  localparam int SW_INPUT = 13;
  localparam int SW_IOUT = 14;
  localparam int SW_VOUT = 15;
  // Voltage detail bit positions
  localparam int VF_OV = 7;
  localparam int VF_UV = 4;
  localparam int VF_MAX_WARN = 3;
  // Current detail bit positions
  localparam int IF_OC = 7;
  localparam int IF_OC_UV = 6;
  localparam int IF_SHARE = 3;
  // Number of outputs (pages)
  localparam int NUM_PAGES = 2;
  // Value of the read data before any command has been taken
  localparam logic [15:0] RDATA_RESET = 16'h0000;
endpackage
`default_nettype wire

// file: tb/status_host.sv
/*
  Host model that issues status reads one at a time.
  Assumes the bank answers one cycle after the strobe edge.
*/
`default_nettype none
module status_host (
  // Clock
  input wire logic clk,
  // Read request
  output logic rd_strobe,
  output logic [7:0] rd_cmd,
  output logic rd_page,
  // Read answer
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_unmapped
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle request lines from time zero
  initial begin
    rd_strobe = 1'b0;
    rd_cmd = 8'h00;
    rd_page = 1'b0;
  end
  // Strobe for one edge, then take the answer in the valid cycle
  task automatic read(input logic [7:0] c, input logic p,
                      output logic [15:0] d, output logic u);
    @(posedge clk);
    rd_strobe <= 1'b1;
    rd_cmd <= c;
    rd_page <= p;
    @(posedge clk);
    rd_strobe <= 1'b0;
    rd_cmd <= ~c; // Released lines do not keep the last value
    rd_page <= ~p;
    @(negedge clk);
    d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx; // Missing answer fails
    u = rd_unmapped;
  endtask
endmodule // status_host
`default_nettype wire

// file: tb/tb_top.sv
/*
  Self-checking bench for the fault status bank.
  Assumes the host model drives the read port.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [21:0] f = 22'h000000;
  logic rd_strobe, rd_valid, rd_unmapped, rd_page, u;
  logic [7:0] rd_cmd;
  logic [15:0] rd_data, d;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] bad_cmds [3] = '{8'h00, 8'h7c, 8'hff};
  // Clock at 100 MHz
  always #5 clk = ~clk;
  power_fault_status_summary dut (.clk(clk), .rst_n(rst_n),
    .out_off(f[1:0]), .vout_ov_fault(f[3:2]), .vout_uv_fault(f[5:4]),
    .vout_max_warn(f[7:6]), .iout_oc_fault(f[9:8]),
    .iout_oc_uv_fault(f[11:10]), .iout_share_fault(f[13:12]),
    .pgood_n(f[15:14]), .vin_uv_fault(f[16]), .input_fault_any(f[17]),
    .temp_fault_any(f[18]), .cml_fault_any(f[19]), .mfr_event(f[20]),
    .other_event(f[21]), .rd_strobe(rd_strobe), .rd_cmd(rd_cmd),
    .rd_page(rd_page), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_unmapped(rd_unmapped));
  status_host host (.clk(clk), .rd_strobe(rd_strobe), .rd_cmd(rd_cmd),
    .rd_page(rd_page), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_unmapped(rd_unmapped));
  // Expected read value from the fault levels
  function automatic logic [15:0] expect_val(input logic [7:0] c,
      input logic p, input logic [21:0] v);
    logic [7:0] sb;
    sb = {1'b0, |v[1:0], |v[3:2], |v[9:8], v[16], v[18], v[19], v[21]};
    case (c)
      8'h78: return {8'h00, sb};
      8'h79: return {|v[7:2], |v[13:8], v[17] | v[16], v[20], |v[15:14],
                     3'h0, sb};
      8'h7a: return {8'h00, v[2+p], 2'h0, v[4+p], v[6+p], 3'h0};
      8'h7b: return {8'h00, v[8+p], v[10+p], 2'h0, v[12+p], 3'h0};
      default: return 16'h0000;
    endcase
  endfunction
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Read one register and compare the answer and the unmapped flag
  task automatic read_check(input logic [7:0] c, input logic p,
      input logic [21:0] v);
    host.read(c, p, d, u);
    check(d, expect_val(c, p, v));
    check({15'h0000, u}, 16'h0000);
  endtask
  // Apply fault levels and read every register on both pages
  task automatic run_case(input logic [21:0] v);
    @(posedge clk);
    f <= v;
    for (int p = 0; p < 2; p++) begin
      read_check(8'h78, p[0], v);
      read_check(8'h79, p[0], v);
      read_check(8'h7a, p[0], v);
      read_check(8'h7b, p[0], v);
    end
  endtask
  // Verdict
  task automatic report_and_stop;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
  // Test sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(rd_data, 16'h0000);
    check({15'h0000, rd_valid}, 16'h0000);
    $display("test reset done");
    run_case(22'h000000);
    run_case(22'h3fffff);
    $display("test extremes done");
    // Reset in mid-run clears the held answer
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check(rd_data, 16'h0000);
    check({14'h0000, rd_valid, rd_unmapped}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    $display("test mid reset done");
    for (int i = 0; i < 22; i++) run_case(22'h000001 << i);
    $display("test walking fault done");
    foreach (bad_cmds[j]) begin
      host.read(bad_cmds[j], 1'b0, d, u);
      check(d, 16'h0000);
      check({15'h0000, u}, 16'h0001);
    end
    $display("test unmapped done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
